// *** rtl/sd_host_descriptor_dma.v ***
// descriptor-driven dma engine with ahb-lite register slave and memory master
`timescale 1ns/1ps
`default_nettype none
`include "sd_dma_defs.vh"
module sd_host_descriptor_dma (
	input wire CLK_IN,
	input wire RST_N_IN,
	// register slave
	input wire HSEL_IN,
	input wire [11:0] HADDR_IN,
	input wire [1:0] HTRANS_IN,
	input wire HWRITE_IN,
	input wire [2:0] HSIZE_IN,
	input wire [31:0] HWDATA_IN,
	input wire HREADY_IN,
	output wire HREADYOUT_OUT,
	output wire HRESP_OUT,
	output reg [31:0] HRDATA_OUT,
	// memory master
	output wire [31:0] M_HADDR_OUT,
	output wire [1:0] M_HTRANS_OUT,
	output wire M_HWRITE_OUT,
	output wire [2:0] M_HSIZE_OUT,
	output wire [2:0] M_HBURST_OUT,
	output wire [31:0] M_HWDATA_OUT,
	input wire [31:0] M_HRDATA_IN,
	input wire M_HREADY_IN,
	// bus interface unit
	input wire TO_CARD_IN,
	input wire COMMAND_DONE_FLAG_IN,
	input wire [6:0] CARD_ERRORS_IN,
	input wire FIFO_TRANSFER_REQUEST_IN,
	output reg FIFO_PUSH_OUT,
	output reg [31:0] FIFO_WDATA_OUT,
	output wire FIFO_POP_OUT,
	input wire [31:0] FIFO_RDATA_IN,
	output wire INTR_OUT
);
	localparam S_IDLE = 4'd0;
	localparam S_FETCH = 4'd1;
	localparam S_CHECK = 4'd2;
	localparam S_SUSP = 4'd3;
	localparam S_WAITCMD = 4'd4;
	localparam S_WAITREQ = 4'd5;
	localparam S_MOVE = 4'd6;
	localparam S_WRBACK = 4'd7;
	localparam S_NEXT = 4'd8;

	function [31:0] word_addr;
		input [31:0] base;
		input [1:0] idx;
		begin
			word_addr = base + {28'h000_0000, idx, 2'b00};
		end
	endfunction

	// ************************************************************
	// register slave
	// ************************************************************
	reg wr_q;
	reg [11:0] addr_q;
	reg [31:0] bus_mode_config_q;
	reg [31:0] list_base_pointer_q;
	reg [31:0] dma_event_enable_q;
	reg [31:0] status_q;
	reg [31:0] status_d;
	reg base_written_q;
	reg [31:0] rd_d;
	wire addr_phase;
	wire wr_poll;
	wire wr_base;
	wire wr_status;
	wire normal_summary;
	wire abnormal_summary;
	wire [31:0] status_view;
	wire ev_tx;
	wire ev_rx;
	wire ev_du;
	wire ev_fault;

	assign addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;
	assign wr_poll = wr_q && (addr_q == `OFS_POLL);
	assign wr_base = wr_q && (addr_q == `OFS_LIST_BASE);
	assign wr_status = wr_q && (addr_q == `OFS_EVT_STATUS);

	// summaries are derived, so they drop as soon as enabled members clear
	assign normal_summary = (status_q[`ST_TX_DONE] && dma_event_enable_q[`ST_TX_DONE]) ||
		(status_q[`ST_RX_DONE] && dma_event_enable_q[`ST_RX_DONE]);
	assign abnormal_summary = (status_q[`ST_DESC_UNAVAIL] && dma_event_enable_q[`ST_DESC_UNAVAIL]) ||
		(status_q[`ST_CARD_FAULT] && dma_event_enable_q[`ST_CARD_FAULT]);
	assign INTR_OUT = (normal_summary && dma_event_enable_q[`ST_NORMAL_SUM]) ||
		(abnormal_summary && dma_event_enable_q[`ST_ABNORMAL_SUM]);
	assign status_view = {22'h00_0000, abnormal_summary, normal_summary, status_q[7:0]};

	reg [3:0] state_q;
	reg [31:0] desc_addr_q;
	reg [31:0] buf_ptr_q;

	always @*
	begin
		case (HADDR_IN)
		`OFS_BUS_MODE: rd_d = bus_mode_config_q;
		`OFS_LIST_BASE: rd_d = list_base_pointer_q;
		`OFS_EVT_STATUS: rd_d = status_view;
		`OFS_EVT_ENABLE: rd_d = dma_event_enable_q;
		`OFS_CUR_DESC: rd_d = desc_addr_q;
		`OFS_CUR_BUF: rd_d = buf_ptr_q;
		default: rd_d = 32'h0000_0000;
		endcase
	end

	always @*
	begin
		status_d = status_q;
		// write one clears; an event in the same cycle still sets
		if (wr_status)
		begin
			status_d = status_d & ~(HWDATA_IN & `ST_WRITABLE);
		end
		if (ev_tx)
		begin
			status_d[`ST_TX_DONE] = 1'b1;
		end
		if (ev_rx)
		begin
			status_d[`ST_RX_DONE] = 1'b1;
		end
		if (ev_du)
		begin
			status_d[`ST_DESC_UNAVAIL] = 1'b1;
		end
		if (ev_fault)
		begin
			status_d[`ST_CARD_FAULT] = 1'b1;
		end
	end

	always @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			wr_q <= 1'b0;
			addr_q <= 12'h000;
			HRDATA_OUT <= 32'h0000_0000;
			bus_mode_config_q <= `BM_RESET;
			list_base_pointer_q <= 32'h0000_0000;
			dma_event_enable_q <= `EN_RESET;
			status_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q <= addr_phase && HWRITE_IN;
			addr_q <= HADDR_IN;
			if (addr_phase && !HWRITE_IN)
			begin
				HRDATA_OUT <= rd_d;
			end
			status_q <= status_d;
			if (wr_q && addr_q == `OFS_BUS_MODE)
			begin
				bus_mode_config_q <= HWDATA_IN;
			end
			if (wr_base)
			begin
				list_base_pointer_q <= {HWDATA_IN[31:2], 2'b00};
			end
			if (wr_q && addr_q == `OFS_EVT_ENABLE)
			begin
				dma_event_enable_q <= HWDATA_IN & 32'h0000_0333;
			end
		end
	end

	// ************************************************************
	// descriptor engine
	// ************************************************************
	reg [1:0] idx_q;
	reg [31:0] d0_q;
	reg [31:0] d1_q;
	reg [31:0] d3_q;
	reg [12:0] remain_q;
	reg [3:0] burst_q;
	reg issued_q;
	reg cmd_ok_q;
	reg fault_q;
	reg req_d;
	reg write_d;
	reg [31:0] addr_d;
	reg [31:0] wdata_d;
	wire mem_done;
	wire [31:0] mem_rdata;
	wire enable;
	wire [3:0] burst_len;
	wire card_fault_summary;
	wire linked_next_flag;
	wire ring_wrap_flag;
	wire final_buffer_flag;
	wire completion_irq_suppress;

	assign enable = bus_mode_config_q[`BM_ENABLE_BIT];
	assign burst_len = {1'b0, bus_mode_config_q[`BM_BURST_MSB:`BM_BURST_LSB]} + 4'h1;
	assign card_fault_summary = |CARD_ERRORS_IN;
	assign linked_next_flag = d0_q[`D0_LINKED];
	assign ring_wrap_flag = d0_q[`D0_WRAP];
	assign final_buffer_flag = d0_q[`D0_FINAL];
	assign completion_irq_suppress = d0_q[`D0_SUPPRESS];

	assign ev_du = (state_q == S_CHECK) && !d0_q[`D0_OWN];
	assign ev_fault = (state_q == S_WAITCMD) && COMMAND_DONE_FLAG_IN && card_fault_summary;
	assign ev_tx = (state_q == S_WRBACK) && mem_done && TO_CARD_IN &&
		!completion_irq_suppress && remain_q == 13'h0000;
	assign ev_rx = (state_q == S_WRBACK) && mem_done && !TO_CARD_IN &&
		!completion_irq_suppress && remain_q == 13'h0000;

	// fifo is show-ahead: the word on FIFO_RDATA_IN is taken with the pop
	assign FIFO_POP_OUT = (state_q == S_MOVE) && !TO_CARD_IN && !issued_q;

	always @*
	begin
		req_d = 1'b0;
		write_d = 1'b0;
		addr_d = 32'h0000_0000;
		wdata_d = 32'h0000_0000;
		case (state_q)
		S_FETCH:
		begin
			req_d = !issued_q;
			addr_d = word_addr(desc_addr_q, idx_q);
		end
		S_MOVE:
		begin
			req_d = !issued_q;
			write_d = !TO_CARD_IN;
			addr_d = buf_ptr_q;
			wdata_d = FIFO_RDATA_IN;
		end
		S_WRBACK:
		begin
			req_d = !issued_q;
			write_d = 1'b1;
			addr_d = desc_addr_q;
			// hand the descriptor back with the fault summary recorded
			wdata_d = {1'b0, fault_q, d0_q[29:0]};
		end
		default:
		begin
			req_d = 1'b0;
		end
		endcase
	end

	always @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			state_q <= S_IDLE;
			desc_addr_q <= 32'h0000_0000;
			buf_ptr_q <= 32'h0000_0000;
			base_written_q <= 1'b0;
			idx_q <= 2'd0;
			d0_q <= 32'h0000_0000;
			d1_q <= 32'h0000_0000;
			d3_q <= 32'h0000_0000;
			remain_q <= 13'h0000;
			burst_q <= 4'h0;
			issued_q <= 1'b0;
			cmd_ok_q <= 1'b0;
			fault_q <= 1'b0;
			FIFO_PUSH_OUT <= 1'b0;
			FIFO_WDATA_OUT <= 32'h0000_0000;
		end
		else
		begin
			FIFO_PUSH_OUT <= 1'b0;
			if (req_d)
			begin
				issued_q <= 1'b1;
			end
			else if (mem_done)
			begin
				issued_q <= 1'b0;
			end
			if (wr_base && state_q == S_IDLE)
			begin
				base_written_q <= 1'b1;
				desc_addr_q <= {HWDATA_IN[31:2], 2'b00};
			end
			case (state_q)
			S_IDLE:
			begin
				// fetching starts once the base pointer is written and enabled
				if (base_written_q && enable)
				begin
					idx_q <= 2'd0;
					state_q <= S_FETCH;
				end
			end
			S_FETCH:
			begin
				if (mem_done)
				begin
					case (idx_q)
					2'd0: d0_q <= mem_rdata;
					2'd1: d1_q <= mem_rdata;
					2'd2: buf_ptr_q <= mem_rdata;
					default: d3_q <= mem_rdata;
					endcase
					idx_q <= idx_q + 2'd1;
					if (idx_q == 2'd3)
					begin
						state_q <= S_CHECK;
					end
				end
			end
			S_CHECK:
			begin
				remain_q <= d1_q[`D1_SIZE_MSB:0];
				fault_q <= 1'b0;
				if (!d0_q[`D0_OWN])
				begin
					state_q <= S_SUSP;
				end
				else if (d1_q[`D1_SIZE_MSB:0] == 13'h0000)
				begin
					// empty first buffer: data begins in the next descriptor
					state_q <= S_WRBACK;
				end
				else if (!cmd_ok_q)
				begin
					state_q <= S_WAITCMD;
				end
				else
				begin
					state_q <= S_WAITREQ;
				end
			end
			S_SUSP:
			begin
				if (wr_poll)
				begin
					idx_q <= 2'd0;
					state_q <= S_FETCH;
				end
			end
			S_WAITCMD:
			begin
				if (COMMAND_DONE_FLAG_IN)
				begin
					if (card_fault_summary)
					begin
						// a failed command returns the descriptor unused
						fault_q <= 1'b1;
						remain_q <= 13'h0000;
						state_q <= S_WRBACK;
					end
					else
					begin
						cmd_ok_q <= 1'b1;
						state_q <= S_WAITREQ;
					end
				end
			end
			S_WAITREQ:
			begin
				if (FIFO_TRANSFER_REQUEST_IN)
				begin
					burst_q <= burst_len;
					state_q <= S_MOVE;
				end
			end
			S_MOVE:
			begin
				if (mem_done)
				begin
					if (TO_CARD_IN)
					begin
						FIFO_PUSH_OUT <= 1'b1;
						FIFO_WDATA_OUT <= mem_rdata;
					end
					buf_ptr_q <= buf_ptr_q + `WORD_STEP;
					remain_q <= remain_q - `SIZE_STEP;
					burst_q <= burst_q - 4'h1;
					if (remain_q == `SIZE_STEP)
					begin
						state_q <= S_WRBACK;
					end
					else if (burst_q == 4'h1)
					begin
						// burst count used up: wait for the next fifo request before moving more words
						state_q <= S_WAITREQ;
					end
				end
			end
			S_WRBACK:
			begin
				if (mem_done)
				begin
					if (final_buffer_flag || fault_q)
					begin
						cmd_ok_q <= 1'b0;
					end
					state_q <= S_NEXT;
				end
			end
			S_NEXT:
			begin
				if (ring_wrap_flag)
				begin
					desc_addr_q <= list_base_pointer_q;
				end
				else if (linked_next_flag)
				begin
					desc_addr_q <= {d3_q[31:2], 2'b00};
				end
				else
				begin
					desc_addr_q <= desc_addr_q + `DESC_STRIDE;
				end
				idx_q <= 2'd0;
				// keep walking; an unowned descriptor parks the engine
				state_q <= enable ? S_FETCH : S_IDLE;
			end
			default:
			begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// memory master
	// ************************************************************
	dma_mem_port u_mem_port (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.req_in(req_d),
		.write_in(write_d),
		.addr_in(addr_d),
		.wdata_in(wdata_d),
		.done_out(mem_done),
		.rdata_out(mem_rdata),
		.haddr_out(M_HADDR_OUT),
		.htrans_out(M_HTRANS_OUT),
		.hwrite_out(M_HWRITE_OUT),
		.hsize_out(M_HSIZE_OUT),
		.hburst_out(M_HBURST_OUT),
		.hwdata_out(M_HWDATA_OUT),
		.hrdata_in(M_HRDATA_IN),
		.hready_in(M_HREADY_IN)
	);
endmodule
`default_nettype wire

// *** rtl/sd_dma_defs.vh ***
// constants of the descriptor dma engine: offsets, fields, reset values
//
// Summary of operation
// - own bit 31 marks an engine descriptor; engine clears it after the data move
// - card fault summary bit 30 is the OR of seven card error conditions
// - ring wrap flag sends the next fetch back to the list base pointer
// - linked flag uses word three as next address; buffer two size stays zero
// - first buffer with zero size: the next descriptor starts the data
// - final buffer descriptor leaves zero bytes remaining; software sizes buffers so
// - suppress flag blocks the transmit or receive done status for that buffer
// - word two is the full 32-bit buffer address
// - linked next address keeps its two low bits zero for non-final descriptors
// - a descriptor is four words; the engine fetches and uses all four
// - a descriptor not owned suspends the engine and flags descriptor unavailable
// - any write to poll demand restarts a suspended engine with a new fetch
// - no data moves before command done arrives without card errors
// - data moves only on a fifo request, in bursts; the last burst stops early when the buffer is done
// - write-to-card reads memory into fifo; read-from-card writes fifo to memory
// - without the final flag the engine fetches the next descriptor and continues
// - transmit done sets its enabled status bit and writes back word zero
// - receive done sets its enabled status bit and writes back word zero
// - status clears on write of one; summaries follow members; irq follows summaries
`ifndef SD_DMA_DEFS_VH
`define SD_DMA_DEFS_VH

// register byte offsets
`define OFS_BUS_MODE 12'h080
`define OFS_POLL 12'h084
`define OFS_LIST_BASE 12'h088
`define OFS_EVT_STATUS 12'h08C
`define OFS_EVT_ENABLE 12'h090
`define OFS_CUR_DESC 12'h094
`define OFS_CUR_BUF 12'h098

// bus mode fields
`define BM_ENABLE_BIT 1
`define BM_BURST_LSB 8
`define BM_BURST_MSB 10
`define BM_RESET 32'h0000_0000

// status and enable bit positions
`define ST_TX_DONE 0
`define ST_RX_DONE 1
`define ST_DESC_UNAVAIL 4
`define ST_CARD_FAULT 5
`define ST_NORMAL_SUM 8
`define ST_ABNORMAL_SUM 9
`define ST_WRITABLE 32'h0000_0033
`define EN_RESET 32'h0000_0000

// descriptor word zero fields and word one size msb
`define D0_OWN 31
`define D0_FAULT 30
`define D0_WRAP 5
`define D0_LINKED 4
`define D0_FIRST 3
`define D0_FINAL 2
`define D0_SUPPRESS 1
`define D1_SIZE_MSB 12

// descriptor geometry
`define DESC_STRIDE 32'h0000_0010
`define WORD_STEP 32'h0000_0004
`define SIZE_STEP 13'h0004

`endif

// *** rtl/dma_mem_port.v ***
// single-word ahb-lite master port used for descriptor and buffer traffic
`timescale 1ns/1ps
`default_nettype none
module dma_mem_port (
	input wire clk_in,
	input wire rst_n_in,
	input wire req_in,
	input wire write_in,
	input wire [31:0] addr_in,
	input wire [31:0] wdata_in,
	output reg done_out,
	output reg [31:0] rdata_out,
	output reg [31:0] haddr_out,
	output reg [1:0] htrans_out,
	output reg hwrite_out,
	output wire [2:0] hsize_out,
	output wire [2:0] hburst_out,
	output reg [31:0] hwdata_out,
	input wire [31:0] hrdata_in,
	input wire hready_in
);
	localparam P_IDLE = 2'd0;
	localparam P_ADDR = 2'd1;
	localparam P_DATA = 2'd2;

	reg [1:0] state_q;
	reg [31:0] wdata_q;

	assign hsize_out = 3'h2;
	assign hburst_out = 3'h0;

	always @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= P_IDLE;
			done_out <= 1'b0;
			rdata_out <= 32'h0000_0000;
			haddr_out <= 32'h0000_0000;
			htrans_out <= 2'h0;
			hwrite_out <= 1'b0;
			hwdata_out <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
		end
		else
		begin
			done_out <= 1'b0;
			case (state_q)
			P_IDLE:
			begin
				if (req_in)
				begin
					haddr_out <= addr_in;
					hwrite_out <= write_in;
					htrans_out <= 2'h2;
					wdata_q <= wdata_in;
					state_q <= P_ADDR;
				end
			end
			P_ADDR:
			begin
				// address phase stands until the slave samples it
				if (hready_in)
				begin
					htrans_out <= 2'h0;
					hwdata_out <= wdata_q;
					state_q <= P_DATA;
				end
			end
			P_DATA:
			begin
				if (hready_in)
				begin
					rdata_out <= hrdata_in;
					done_out <= 1'b1;
					state_q <= P_IDLE;
				end
			end
			default:
			begin
				state_q <= P_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** sim/sd_dma_sva.sv ***
// assertion checker bound to the descriptor dma engine ports
`timescale 1ns/1ps
`default_nettype none
module sd_dma_sva (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic HREADYOUT_OUT,
	input wire logic HRESP_OUT,
	input wire logic [31:0] M_HADDR_OUT,
	input wire logic [1:0] M_HTRANS_OUT,
	input wire logic M_HWRITE_OUT,
	input wire logic [2:0] M_HSIZE_OUT,
	input wire logic [2:0] M_HBURST_OUT,
	input wire logic [31:0] M_HWDATA_OUT,
	input wire logic [31:0] M_HRDATA_IN,
	input wire logic M_HREADY_IN,
	input wire logic TO_CARD_IN,
	input wire logic COMMAND_DONE_FLAG_IN,
	input wire logic [6:0] CARD_ERRORS_IN,
	input wire logic FIFO_PUSH_OUT,
	input wire logic [31:0] FIFO_WDATA_OUT,
	input wire logic FIFO_POP_OUT,
	input wire logic INTR_OUT
);
	logic dp_q;
	logic dw_q;
	logic cmd_q;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// ****************************************
	// master data phase and command tracking
	// ****************************************
	always @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			dp_q <= 1'b0;
			dw_q <= 1'b0;
			cmd_q <= 1'b0;
		end
		else
		begin
			if (M_HREADY_IN)
			begin
				dp_q <= M_HTRANS_OUT[1];
				dw_q <= M_HWRITE_OUT;
			end
			if (COMMAND_DONE_FLAG_IN && CARD_ERRORS_IN == 7'h00)
				cmd_q <= 1'b1;
		end
	end
	sequence s_addr_held;
		M_HTRANS_OUT == 2'h2 && !M_HREADY_IN;
	endsequence
	sequence s_addr_taken;
		M_HTRANS_OUT == 2'h2 && M_HREADY_IN;
	endsequence
	property p_slave_okay;
		HREADYOUT_OUT && !HRESP_OUT;
	endproperty
	a_slave_okay: assert property (p_slave_okay)
		else $error("register slave not ready or not okay");
	property p_single_word;
		M_HSIZE_OUT == 3'h2 && M_HBURST_OUT == 3'h0;
	endproperty
	a_single_word: assert property (p_single_word)
		else $error("master transfer not a single word");
	property p_addr_hold;
		s_addr_held |=> M_HTRANS_OUT == 2'h2 && $stable(M_HADDR_OUT) && $stable(M_HWRITE_OUT);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("master address phase dropped during wait");
	property p_gap;
		s_addr_taken |=> M_HTRANS_OUT == 2'h0;
	endproperty
	a_gap: assert property (p_gap)
		else $error("master issued back to back transfers");
	property p_push_src;
		FIFO_PUSH_OUT |-> $past(dp_q && !dw_q && M_HREADY_IN, 2) && FIFO_WDATA_OUT == $past(M_HRDATA_IN, 2);
	endproperty
	a_push_src: assert property (p_push_src)
		else $error("fifo push not fed by a completed memory read");
	property p_pop_write;
		FIFO_POP_OUT |-> !TO_CARD_IN ##1 M_HTRANS_OUT == 2'h2 && M_HWRITE_OUT;
	endproperty
	a_pop_write: assert property (p_pop_write)
		else $error("fifo pop not followed by a memory write");
	property p_own_release;
		dp_q && dw_q && M_HREADY_IN && TO_CARD_IN |-> !M_HWDATA_OUT[31];
	endproperty
	a_own_release: assert property (p_own_release)
		else $error("writeback keeps the ownership bit");
	property p_after_reset;
		$past(!RST_N_IN) |-> M_HTRANS_OUT == 2'h0 && !FIFO_PUSH_OUT && !INTR_OUT;
	endproperty
	a_after_reset: assert property (p_after_reset)
		else $error("engine active right after reset");
	property p_move_after_cmd;
		FIFO_PUSH_OUT || FIFO_POP_OUT |-> cmd_q;
	endproperty
	a_move_after_cmd: assert property (p_move_after_cmd)
		else $error("data moved before a clean command done");
endmodule
bind sd_host_descriptor_dma sd_dma_sva u_sd_dma_sva (.*);
`default_nettype wire

// *** sim/ahb_mem_model.sv ***
// behavioural host memory answering the engine's ahb-lite master port
`timescale 1ns/1ps
`default_nettype none
module ahb_mem_model (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hready_out
);
	logic [31:0] mem [0:255] = '{default: 32'h0000_0000};
	logic [7:0] a_q = 8'h00;
	logic w_q = 1'b0;
	logic dp_q = 1'b0;
	logic stall_q = 1'b0;
	// slow mode stalls every other cycle, in address and data phase alike
	assign hready_out = !stall_q;
	// outside a read data phase the bus shows inverted data so stale words never match
	assign hrdata_out = (dp_q && !w_q) ? mem[a_q] : ~mem[a_q];
	always @(posedge clk_in)
	begin
		stall_q <= slow_in && !stall_q;
		if (hready_out)
		begin
			dp_q <= htrans_in[1];
			w_q <= hwrite_in;
			a_q <= haddr_in[9:2];
			if (dp_q && w_q)
				mem[a_q] <= hwdata_in;
		end
	end
endmodule
`default_nettype wire

// *** sim/sd_host_descriptor_dma_tb.sv ***
// self-checking bench for the descriptor dma engine
`timescale 1ns/1ps
`default_nettype none
`include "sd_dma_defs.vh"
module sd_host_descriptor_dma_tb;
	logic CLK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic HSEL_IN = 1'b0;
	logic [11:0] HADDR_IN = 12'h000;
	logic [1:0] HTRANS_IN = 2'h0;
	logic HWRITE_IN = 1'b0;
	logic [2:0] HSIZE_IN = 3'h2;
	logic [31:0] HWDATA_IN = 32'h0000_0000;
	logic TO_CARD_IN = 1'b1;
	logic COMMAND_DONE_FLAG_IN = 1'b0;
	logic FIFO_TRANSFER_REQUEST_IN = 1'b0;
	logic slow = 1'b1;
	logic [6:0] CARD_ERRORS_IN = 7'h00;
	logic [31:0] FIFO_RDATA_IN = 32'hA5A5_0000;
	wire logic HREADY_IN, HREADYOUT_OUT, HRESP_OUT, M_HWRITE_OUT, M_HREADY_IN;
	wire logic FIFO_PUSH_OUT, FIFO_POP_OUT, INTR_OUT;
	wire logic [31:0] HRDATA_OUT, M_HADDR_OUT, M_HWDATA_OUT, M_HRDATA_IN, FIFO_WDATA_OUT;
	wire logic [1:0] M_HTRANS_OUT;
	wire logic [2:0] M_HSIZE_OUT, M_HBURST_OUT;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] pushed [$];
	assign HREADY_IN = HREADYOUT_OUT;
	sd_host_descriptor_dma u_sd_host_descriptor_dma (.*);
	ahb_mem_model u_ahb_mem_model (.clk_in(CLK_IN), .slow_in(slow), .haddr_in(M_HADDR_OUT),
		.htrans_in(M_HTRANS_OUT), .hwrite_in(M_HWRITE_OUT), .hwdata_in(M_HWDATA_OUT),
		.hrdata_out(M_HRDATA_IN), .hready_out(M_HREADY_IN));
	always #2.5 CLK_IN = ~CLK_IN;
	// pop data is show-ahead, so the next word is offered once a pop is seen
	always @(posedge CLK_IN)
	begin
		if (FIFO_PUSH_OUT === 1'b1)
			pushed.push_back(FIFO_WDATA_OUT);
		if (FIFO_POP_OUT === 1'b1)
			FIFO_RDATA_IN <= FIFO_RDATA_IN + 32'h1;
	end
	// ****************************************
	// bus tasks and comparisons
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		HSEL_IN <= 1'b1;
		HADDR_IN <= a;
		HTRANS_IN <= 2'h2;
		HWRITE_IN <= w;
		do @(posedge CLK_IN); while (HREADY_IN !== 1'b1);
		HSEL_IN <= 1'b0;
		HTRANS_IN <= 2'h0;
		HWDATA_IN <= d;
		do @(posedge CLK_IN); while (HREADY_IN !== 1'b1);
		r = HRDATA_OUT;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0000_0000, r);
	endtask
	task automatic wait_st(input logic [31:0] m);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < 400 && (r & m) !== m; i++)
			rd(`OFS_EVT_STATUS, r);
		chk("status event", m, r & m);
	endtask
	task automatic put_desc(input logic [31:0] p, input logic [31:0] c, input logic [31:0] s,
		input logic [31:0] ba, input logic [31:0] nx);
		u_ahb_mem_model.mem[p[9:2]] = c;
		u_ahb_mem_model.mem[p[9:2] + 8'h1] = s;
		u_ahb_mem_model.mem[p[9:2] + 8'h2] = ba;
		u_ahb_mem_model.mem[p[9:2] + 8'h3] = nx;
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge CLK_IN);
		$display("[FAIL] watchdog expected finish seen timeout");
		n_errors++;
		conclude();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		logic [31:0] r;
		logic [31:0] p;
		logic [31:0] rx0;
		logic [6:0] e;
		logic [11:0] ofs [4];
		ofs = '{`OFS_BUS_MODE, `OFS_EVT_STATUS, `OFS_EVT_ENABLE, 12'h0FC};
		repeat (8) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		@(posedge CLK_IN);
		foreach (ofs[i])
		begin
			rd(ofs[i], r);
			chk("reset value", 32'h0000_0000, r);
		end
		// transmit over a linked pair that wraps back to an already returned base
		for (int i = 0; i < 2; i++)
		begin
			u_ahb_mem_model.mem[8'h80 + i] = 32'hC0DE_0000 + i;
			u_ahb_mem_model.mem[8'h88 + i] = 32'hC0DE_0002 + i;
		end
		wr(`OFS_BUS_MODE, 32'h0000_0002);
		wr(`OFS_EVT_ENABLE, 32'h0000_0333);
		put_desc(32'h100, 32'h8000_0018, 32'h8, 32'h200, 32'h180);
		put_desc(32'h180, 32'h8000_0024, 32'h8, 32'h220, 32'h0);
		wr(`OFS_LIST_BASE, 32'h0000_0100);
		FIFO_TRANSFER_REQUEST_IN <= 1'b1;
		repeat (60) @(posedge CLK_IN);
		chk("push before command", 32'h0, 32'(pushed.size()));
		COMMAND_DONE_FLAG_IN <= 1'b1;
		wait_st(32'h0000_0011);
		COMMAND_DONE_FLAG_IN <= 1'b0;
		chk("words pushed", 32'h4, 32'(pushed.size()));
		foreach (pushed[i])
			chk("pushed word", 32'hC0DE_0000 + i, pushed[i]);
		chk("first writeback", 32'h0000_0018, u_ahb_mem_model.mem[8'h40]);
		chk("last writeback", 32'h0000_0024, u_ahb_mem_model.mem[8'h60]);
		rd(`OFS_CUR_DESC, r);
		chk("wrap to base", 32'h0000_0100, r);
		rd(`OFS_EVT_STATUS, r);
		chk("summary bits", 32'h0000_0311, r);
		chk("irq raised", 32'h1, {31'h0, INTR_OUT});
		wr(`OFS_EVT_STATUS, 32'h0000_0033);
		rd(`OFS_EVT_STATUS, r);
		chk("status cleared", 32'h0, r & 32'h0000_0333);
		chk("irq cleared", 32'h0, {31'h0, INTR_OUT});
		// receive: empty first buffer, sequential then linked step, prompt memory
		TO_CARD_IN <= 1'b0;
		slow <= 1'b0;
		rx0 = FIFO_RDATA_IN;
		put_desc(32'h100, 32'h8000_000A, 32'h0, 32'h300, 32'h0);
		put_desc(32'h110, 32'h8000_0010, 32'h4, 32'h300, 32'h140);
		put_desc(32'h140, 32'h8000_0004, 32'h4, 32'h304, 32'h0);
		wr(`OFS_POLL, 32'h0000_0000);
		COMMAND_DONE_FLAG_IN <= 1'b1;
		wait_st(32'h0000_0012);
		COMMAND_DONE_FLAG_IN <= 1'b0;
		chk("rx word 0", rx0, u_ahb_mem_model.mem[8'hC0]);
		chk("rx word 1", rx0 + 32'h1, u_ahb_mem_model.mem[8'hC1]);
		chk("rx writeback", 32'h0000_0004, u_ahb_mem_model.mem[8'h50]);
		rd(`OFS_CUR_DESC, r);
		chk("sequential next", 32'h0000_0150, r);
		wr(`OFS_EVT_STATUS, 32'h0000_0033);
		// every card fault alone, then a clean suppressed transmit
		TO_CARD_IN <= 1'b1;
		p = 32'h150;
		for (int i = 0; i < 8; i++)
		begin
			e = (i < 7) ? 7'(1 << i) : 7'h00;
			put_desc(p, 32'h8000_000E, 32'h4, 32'h200, 32'h0);
			wr(`OFS_POLL, 32'hFFFF_FFFF);
			CARD_ERRORS_IN <= e;
			COMMAND_DONE_FLAG_IN <= 1'b1;
			wait_st(32'h0000_0010);
			COMMAND_DONE_FLAG_IN <= 1'b0;
			chk("fault writeback", {1'b0, |e, 30'h0000_000E}, u_ahb_mem_model.mem[p[9:2]]);
			rd(`OFS_EVT_STATUS, r);
			chk("fault status", {26'h0, |e, 5'h10}, r & 32'h0000_0033);
			wr(`OFS_EVT_STATUS, 32'h0000_0033);
			p = p + 32'h10;
		end
		conclude();
	end
endmodule
`default_nettype wire
